// ==== inc/tmc_pkg.sv ====
/*
 * Shared constants and carrier types for the thermal monitor control block:
 * register offsets, field positions, reset values and the port structs.
 * Assumes a 64-bit configuration register port on the core clock.
 */
package tmc_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 64;
    localparam int unsigned GROUPS = 4;

    // Register offsets
    localparam logic [15:0] OFS_SAMPLE     = 16'h0198;
    localparam logic [15:0] OFS_CELSIUS    = 16'h0428;
    localparam logic [15:0] OFS_HOT        = 16'h1460;
    localparam logic [15:0] OFS_COLD       = 16'h1468;
    localparam logic [15:0] OFS_STATUS     = 16'h1470;
    localparam logic [15:0] OFS_THROTTLE   = 16'h1480;
    localparam logic [15:0] OFS_THR_UPPER  = 16'h1490;
    localparam logic [15:0] OFS_PIN        = 16'h1498;
    localparam logic [15:0] OFS_UNIT_CFG   = 16'h1580;
    localparam logic [15:0] OFS_UNIT_DATA  = 16'h1588;
    localparam logic [15:0] UNIT_ADDR_MASK = 16'hFFCF;
    localparam int unsigned UNIT_SHIFT     = 4;

    // Threshold group layout, repeated every GRP_STRIDE bits
    localparam int unsigned GRP_STRIDE  = 16;
    localparam int unsigned GRP_THR_LSB = 0;
    localparam int unsigned GRP_THR_W   = 8;
    localparam int unsigned GRP_EN_BIT  = 8;
    localparam int unsigned GRP_SEL_LSB = 10;
    localparam int unsigned GRP_DIV_LSB = 12;
    localparam int unsigned UPPER_COLD_LSB = 32;

    // Status and pin control fields
    localparam int unsigned STAT_HOT_BIT  = 0;
    localparam int unsigned STAT_COLD_BIT = 1;
    localparam int unsigned PIN_DIR_BIT   = 0;
    localparam int unsigned PIN_OSEL_LSB  = 4;
    localparam int unsigned PIN_DIV_LSB   = 8;
    localparam int unsigned PIN_TSEL_LSB  = 16;

    // Sampling register fields
    localparam int unsigned SMP_OVR_A_BIT  = 24;
    localparam int unsigned SMP_OVR_B_BIT  = 25;
    localparam int unsigned SMP_CODE_A_LSB = 32;
    localparam int unsigned SMP_CODE_B_LSB = 48;
    localparam int unsigned CEL_A_LSB      = 0;
    localparam int unsigned CEL_B_LSB      = 16;

    // Code to Celsius: code * 731 / 0x4000 - 273
    localparam logic [9:0]  CEL_MUL    = 10'h2DB;
    localparam int unsigned CEL_SHIFT  = 14;
    localparam logic [15:0] CEL_OFFSET = 16'h0111;

    // Sensor unit configuration and data fields
    localparam int unsigned UCFG_W           = 12;
    localparam int unsigned UCFG_MODE_BIT    = 2;
    localparam int unsigned UCFG_CLUSTER_LSB = 4;
    localparam int unsigned UDAT_MODE_BIT    = 3;
    localparam int unsigned UDAT_CLUSTER_LSB = 4;
    localparam int unsigned UDAT_OVR_BIT     = 7;
    localparam int unsigned UDAT_LSB         = 16;
    localparam int unsigned UDAT_W           = 14;

    // Writable bits and reset values
    localparam logic [63:0] IRQ_CTRL_MASK = 64'h0DFF_0DFF_0DFF_0DFF;
    localparam logic [63:0] THROTTLE_MASK = 64'h7DFF_7DFF_7DFF_7DFF;
    localparam logic [63:0] PIN_MASK      = 64'h0000_0000_0003_0731;
    localparam logic [63:0] CTRL_RST      = 64'h0000_0000_0000_0000;
    localparam logic [63:0] PIN_RST       = 64'h0000_0000_0000_0001;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [63:0] wdata;
    } tmc_cfg_req_t;

    typedef struct packed {
        logic        ack;
        logic [63:0] rdata;
    } tmc_cfg_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] sensor_a_code;
        logic [15:0] sensor_b_code;
        logic        sensor_a_over_range;
        logic        sensor_b_over_range;
    } tmc_sample_t;

endpackage

// ==== rtl/tmc_group_cmp.sv ====
/*
 * One threshold group: picks a sensor's Celsius value and compares it
 * against a signed threshold, above or below.
 * Assumes both temperatures are 16-bit two's complement Celsius values.
 */
`timescale 1ns/1ps
module tmc_group_cmp #(
    parameter int unsigned TW = 8
) (
    input  wire logic [TW-1:0] threshold,
    input  wire logic          enable,
    input  wire logic [1:0]    source_select,
    input  wire logic          below,
    input  wire logic [15:0]   temp_a,
    input  wire logic [15:0]   temp_b,
    output logic               hit
);
    logic signed [15:0] thr;
    logic signed [15:0] temp;
    logic               src_ok;

    always_comb begin
        thr    = 16'($signed(threshold));
        // Only sources 0 and 1 exist
        src_ok = (source_select[1] == 1'b0);
        temp   = source_select[0] ? $signed(temp_b) : $signed(temp_a);
        if (!enable || !src_ok) begin
            hit = 1'b0;
        end else if (below) begin
            hit = (temp < thr);
        end else begin
            hit = (temp > thr);
        end
    end
endmodule // tmc_group_cmp

// ==== rtl/tmc_thermal_ctrl.sv ====
/*
 * Thermal monitor control: sensor readout, high/low temperature status,
 * automatic throttling, hot-alert and thermal-trip pins, sensor unit setup.
 * Assumes samples and the config register port come from core-clock logic;
 * the hot-alert pin input is asynchronous and synchronised here.
 */
//
// Contract
// - Read-only Celsius register at 0x0428
// - Four hot groups: threshold, enable, selector
// - Four cold groups interrupt below threshold
// - Disabled group never raises anything
// - Selector picks sensor; only 0, 1 valid
// - Status bits hot/cold; any write clears
// - Four throttle groups, group 0 highest priority
// - Each throttle group carries 3-bit divider
// - Division applied per node scaling mode; node scaling mode here leaves the clock undivided
// - Upper threshold bytes in 0x1490
// - Hot-alert two-way, trip output-only pin
// - Pin control bit 0: 0 output, 1 input
// - Low hot-alert input throttles by pin divider
// - Bits 5:4 pick hot group onto pin
// - Bits 17:16 pick hot group for trip
// - Unit config at 0x1580, data 0x1588, id<<4
// - Unit config: bit 2 mode, 6:4 point
`timescale 1ns/1ps
module tmc_thermal_ctrl (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire tmc_pkg::tmc_cfg_req_t cfg_req,
    output tmc_pkg::tmc_cfg_rsp_t      cfg_rsp,
    input  wire tmc_pkg::tmc_sample_t  sample,
    input  wire logic                  freq_scale_mode_node,
    input  wire logic                  hot_alert_n_i,
    output logic                       hot_alert_n_o,
    output logic                       hot_alert_n_oe,
    output logic                       thermal_trip_n,
    output logic                       throttle_active,
    output logic [2:0]                 throttle_divider,
    output logic                       core_clk_en,
    output logic [1:0]                 irq_status,
    output logic [47:0]                unit_config
);
    import tmc_pkg::*;

    typedef struct packed {
        logic [63:0]       hot_ctrl;
        logic [63:0]       cold_ctrl;
        logic [63:0]       throttle_ctrl;
        logic [63:0]       thr_upper;
        logic [63:0]       pin_ctrl;
        logic [3:0][11:0]  unit_cfg;
        logic [15:0]       code_a;
        logic [15:0]       code_b;
        logic              over_a;
        logic              over_b;
        logic [15:0]       cel_a;
        logic [15:0]       cel_b;
        logic              eval;
        logic [1:0]        status;
        logic              pin_sync1;
        logic              pin_sync2;
        logic              pin_o;
        logic              trip_n;
        logic              throttle_on;
        logic [2:0]        divider;
        logic [2:0]        div_cnt;
        logic              clk_en;
        tmc_cfg_rsp_t      rsp;
    } tmc_state_t;

    tmc_state_t st;
    tmc_state_t next_st;

    logic [3:0] hot_hit;
    logic [3:0] cold_hit;
    logic [3:0] throttle_hit;

    function automatic logic [15:0] to_celsius(input logic [15:0] code);
        logic [25:0] prod;
        prod = 26'(code) * 26'(CEL_MUL);
        return {4'h0, prod[25:14]} - CEL_OFFSET;
    endfunction

    // Comparators for all three group kinds
    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        localparam int unsigned B = g * GRP_STRIDE;
        tmc_group_cmp #(.TW(8)) u_hot (
            .threshold    (st.hot_ctrl[B+GRP_THR_LSB +: GRP_THR_W]),
            .enable       (st.hot_ctrl[B+GRP_EN_BIT]),
            .source_select(st.hot_ctrl[B+GRP_SEL_LSB +: 2]),
            .below        (1'b0),
            .temp_a       (st.cel_a),
            .temp_b       (st.cel_b),
            .hit          (hot_hit[g])
        );
        tmc_group_cmp #(.TW(8)) u_cold (
            .threshold    (st.cold_ctrl[B+GRP_THR_LSB +: GRP_THR_W]),
            .enable       (st.cold_ctrl[B+GRP_EN_BIT]),
            .source_select(st.cold_ctrl[B+GRP_SEL_LSB +: 2]),
            .below        (1'b1),
            .temp_a       (st.cel_a),
            .temp_b       (st.cel_b),
            .hit          (cold_hit[g])
        );
        // Upper byte joins the 8-bit threshold
        tmc_group_cmp #(.TW(16)) u_thr (
            .threshold    ({st.thr_upper[g*8 +: 8], st.throttle_ctrl[B+GRP_THR_LSB +: 8]}),
            .enable       (st.throttle_ctrl[B+GRP_EN_BIT]),
            .source_select(st.throttle_ctrl[B+GRP_SEL_LSB +: 2]),
            .below        (1'b0),
            .temp_a       (st.cel_a),
            .temp_b       (st.cel_b),
            .hit          (throttle_hit[g])
        );
    end

    function automatic logic [63:0] read_reg(input tmc_state_t s, input logic [15:0] a);
        logic [63:0] r;
        logic [1:0]  idx;
        r   = '0;
        idx = a[UNIT_SHIFT +: 2];
        case (a)
            OFS_SAMPLE: begin
                r[SMP_OVR_A_BIT]       = s.over_a;
                r[SMP_OVR_B_BIT]       = s.over_b;
                r[SMP_CODE_A_LSB +: 16] = s.code_a;
                r[SMP_CODE_B_LSB +: 16] = s.code_b;
            end
            OFS_CELSIUS: begin
                r[CEL_A_LSB +: 16] = s.cel_a;
                r[CEL_B_LSB +: 16] = s.cel_b;
            end
            OFS_HOT:       r = s.hot_ctrl;
            OFS_COLD:      r = s.cold_ctrl;
            OFS_STATUS:    r[1:0] = s.status;
            OFS_THROTTLE:  r = s.throttle_ctrl;
            OFS_THR_UPPER: r = s.thr_upper;
            OFS_PIN:       r = s.pin_ctrl;
            default: begin
                if ((a & UNIT_ADDR_MASK) == OFS_UNIT_CFG) begin
                    r[UCFG_W-1:0] = s.unit_cfg[idx];
                end else if ((a & UNIT_ADDR_MASK) == OFS_UNIT_DATA) begin
                    // Mode and point echo the unit's setup
                    r[UDAT_MODE_BIT]         = s.unit_cfg[idx][UCFG_MODE_BIT];
                    r[UDAT_CLUSTER_LSB +: 3] = s.unit_cfg[idx][UCFG_CLUSTER_LSB +: 3];
                    if (idx == 2'h0) begin
                        r[UDAT_OVR_BIT]         = s.over_a;
                        r[UDAT_LSB +: UDAT_W]   = s.code_a[UDAT_W-1:0];
                    end else if (idx == 2'h1) begin
                        r[UDAT_OVR_BIT]         = s.over_b;
                        r[UDAT_LSB +: UDAT_W]   = s.code_b[UDAT_W-1:0];
                    end
                end
            end
        endcase
        return r;
    endfunction

    always_comb begin
        logic       wr;
        logic [1:0] idx;
        logic       found;
        logic [2:0] div_sel;
        wr      = cfg_req.valid && cfg_req.write;
        idx     = cfg_req.addr[UNIT_SHIFT +: 2];
        found   = 1'b0;
        div_sel = 3'h0;
        next_st = st;

        // Sample capture; comparisons follow one cycle later
        next_st.eval = sample.valid;
        if (sample.valid) begin
            next_st.code_a = sample.sensor_a_code;
            next_st.code_b = sample.sensor_b_code;
            next_st.over_a = sample.sensor_a_over_range;
            next_st.over_b = sample.sensor_b_over_range;
            next_st.cel_a  = to_celsius(sample.sensor_a_code);
            next_st.cel_b  = to_celsius(sample.sensor_b_code);
        end

        // Register writes
        if (wr) begin
            case (cfg_req.addr)
                OFS_HOT:       next_st.hot_ctrl      = cfg_req.wdata & IRQ_CTRL_MASK;
                OFS_COLD:      next_st.cold_ctrl     = cfg_req.wdata & IRQ_CTRL_MASK;
                OFS_STATUS:    next_st.status        = 2'h0;
                OFS_THROTTLE:  next_st.throttle_ctrl = cfg_req.wdata & THROTTLE_MASK;
                OFS_THR_UPPER: next_st.thr_upper     = cfg_req.wdata;
                OFS_PIN:       next_st.pin_ctrl      = cfg_req.wdata & PIN_MASK;
                default: begin
                    if ((cfg_req.addr & UNIT_ADDR_MASK) == OFS_UNIT_CFG) begin
                        next_st.unit_cfg[idx] = cfg_req.wdata[UCFG_W-1:0];
                    end
                end
            endcase
        end

        // Sticky status; a new event wins over a same-cycle clear
        if (st.eval && |hot_hit) begin
            next_st.status[STAT_HOT_BIT] = 1'b1;
        end
        if (st.eval && |cold_hit) begin
            next_st.status[STAT_COLD_BIT] = 1'b1;
        end

        // Register port answer one cycle after the request
        next_st.rsp.ack   = cfg_req.valid;
        next_st.rsp.rdata = cfg_req.valid && !cfg_req.write ?
                            read_reg(st, cfg_req.addr) : 64'h0;

        // Pin input synchroniser
        next_st.pin_sync1 = hot_alert_n_i;
        next_st.pin_sync2 = st.pin_sync1;

        // Pin outputs follow the selected hot groups
        next_st.pin_o  = ~hot_hit[st.pin_ctrl[PIN_OSEL_LSB +: 2]];
        next_st.trip_n = ~hot_hit[st.pin_ctrl[PIN_TSEL_LSB +: 2]];

        // Throttle source: group 0 first, then the hot-alert input
        for (int g = GROUPS - 1; g >= 0; g--) begin
            if (throttle_hit[g]) begin
                found   = 1'b1;
                div_sel = st.throttle_ctrl[g*GRP_STRIDE+GRP_DIV_LSB +: 3];
            end
        end
        if (!found && st.pin_ctrl[PIN_DIR_BIT] && !st.pin_sync2) begin
            found   = 1'b1;
            div_sel = st.pin_ctrl[PIN_DIV_LSB +: 3];
        end
        next_st.throttle_on = found;
        next_st.divider     = found ? div_sel : 3'h0;

        // Clock enable divider; node scaling mode leaves the clock whole
        if (!st.throttle_on || freq_scale_mode_node || st.divider <= 3'h1) begin
            next_st.clk_en  = 1'b1;
            next_st.div_cnt = 3'h0;
        end else if (st.div_cnt == 3'h0) begin
            next_st.clk_en  = 1'b1;
            next_st.div_cnt = st.divider - 3'h1;
        end else begin
            next_st.clk_en  = 1'b0;
            next_st.div_cnt = st.div_cnt - 3'h1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st               <= '0;
            st.hot_ctrl      <= CTRL_RST;
            st.cold_ctrl     <= CTRL_RST;
            st.throttle_ctrl <= CTRL_RST;
            st.thr_upper     <= CTRL_RST;
            st.pin_ctrl      <= PIN_RST;
            st.pin_sync1     <= 1'b1;
            st.pin_sync2     <= 1'b1;
            st.pin_o         <= 1'b1;
            st.trip_n        <= 1'b1;
            st.clk_en        <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign cfg_rsp          = st.rsp;
    assign hot_alert_n_o    = st.pin_o;
    assign hot_alert_n_oe   = ~st.pin_ctrl[PIN_DIR_BIT];
    assign thermal_trip_n   = st.trip_n;
    assign throttle_active  = st.throttle_on;
    assign throttle_divider = st.divider;
    assign core_clk_en      = st.clk_en;
    assign irq_status       = st.status;
    assign unit_config      = st.unit_cfg;

    // Checks
    chk_status_clear: assert property (@(posedge clk) disable iff (!arst_n)
        cfg_req.valid && cfg_req.write && cfg_req.addr == OFS_STATUS && !st.eval
        |=> st.status == 2'h0)
        else $error("status not cleared by write");

    chk_hot_set: assert property (@(posedge clk) disable iff (!arst_n)
        st.eval && |hot_hit |=> st.status[STAT_HOT_BIT])
        else $error("hot event lost");

    chk_cold_set: assert property (@(posedge clk) disable iff (!arst_n)
        st.eval && |cold_hit |=> st.status[STAT_COLD_BIT])
        else $error("cold event lost");

    chk_disabled_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        st.hot_ctrl[8] == 1'b0 |-> hot_hit[0] == 1'b0)
        else $error("disabled group fired");

    chk_status_sticky: assert property (@(posedge clk) disable iff (!arst_n)
        st.status[STAT_HOT_BIT] && !(cfg_req.valid && cfg_req.write)
        |=> st.status[STAT_HOT_BIT])
        else $error("hot status dropped");

    chk_read_ack: assert property (@(posedge clk) disable iff (!arst_n)
        cfg_req.valid && !cfg_req.write && cfg_req.addr == OFS_CELSIUS
        |=> cfg_rsp.ack && cfg_rsp.rdata[15:0] == $past(st.cel_a))
        else $error("celsius read wrong");

    chk_trip_follow: assert property (@(posedge clk) disable iff (!arst_n)
        $stable(st.pin_ctrl) && $stable(hot_hit)
        |-> thermal_trip_n == ~hot_hit[st.pin_ctrl[PIN_TSEL_LSB +: 2]])
        else $error("trip pin mismatch");

    chk_group0_prio: assert property (@(posedge clk) disable iff (!arst_n)
        throttle_hit[0] |=> throttle_active
            && throttle_divider == $past(st.throttle_ctrl[GRP_DIV_LSB +: 3]))
        else $error("group 0 priority lost");

    chk_pin_throttle: assert property (@(posedge clk) disable iff (!arst_n)
        throttle_hit == 4'h0 && st.pin_ctrl[PIN_DIR_BIT] && !st.pin_sync2
        |=> throttle_active && throttle_divider == $past(st.pin_ctrl[PIN_DIV_LSB +: 3]))
        else $error("pin throttle missing");

    chk_pin_dir: assert property (@(posedge clk) disable iff (!arst_n)
        hot_alert_n_oe == !st.pin_ctrl[PIN_DIR_BIT])
        else $error("pin direction wrong");
endmodule // tmc_thermal_ctrl

// ==== bench/tmc_ext_partner.sv ====
/*
 * Far side of the thermal pins: external hot-alert detector and power controller.
 * Assumes the device splits the hot-alert pin into level, enable and input.
 */
`timescale 1ns/1ps
module tmc_ext_partner (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic pull_low,
    input  wire logic hot_alert_n_o,
    input  wire logic hot_alert_n_oe,
    input  wire logic thermal_trip_n,
    output logic      hot_alert_n_i,
    output logic      power_cut
);
    // Pulled-up wire, low if either party pulls it
    assign hot_alert_n_i = (hot_alert_n_oe ? hot_alert_n_o : 1'b1) & ~pull_low;
    // Power removed once trip is seen low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            power_cut <= 1'b0;
        end else begin
            power_cut <= power_cut | ~thermal_trip_n;
        end
    end
endmodule // tmc_ext_partner

// ==== bench/tmc_thermal_ctrl_test.sv ====
/*
 * Self-checking bench for the thermal monitor control block.
 * Assumes tmc_pkg, the design and tmc_ext_partner are compiled first.
 */
`timescale 1ns/1ps
module tmc_thermal_ctrl_test;
    import tmc_pkg::*;
    logic         clk = 1'b0;
    logic         arst_n = 1'b0;
    tmc_cfg_req_t req = '0;
    tmc_cfg_rsp_t rsp;
    tmc_sample_t  smp = '0;
    logic         mode = 1'b0;
    logic         pull = 1'b0;
    logic         ha_o, ha_oe, ha_i, trip_n, act, clk_en, cut;
    logic [2:0]   div;
    logic [1:0]   irq;
    logic [47:0]  ucfg;
    logic [64:0]  exq[$];
    logic [15:0]  ka, kb, ca, cb;
    logic [7:0]   t;
    int           failures = 0;
    int           tests_run = 0;
    int           cyc = 0;
    int           n;

    always #2.5 clk = ~clk;

    tmc_thermal_ctrl i_tmc_thermal_ctrl (.clk(clk), .arst_n(arst_n), .cfg_req(req),
        .cfg_rsp(rsp), .sample(smp), .freq_scale_mode_node(mode), .hot_alert_n_i(ha_i),
        .hot_alert_n_o(ha_o), .hot_alert_n_oe(ha_oe), .thermal_trip_n(trip_n),
        .throttle_active(act), .throttle_divider(div), .core_clk_en(clk_en),
        .irq_status(irq), .unit_config(ucfg));
    tmc_ext_partner i_tmc_ext_partner (.clk(clk), .arst_n(arst_n), .pull_low(pull),
        .hot_alert_n_o(ha_o), .hot_alert_n_oe(ha_oe), .thermal_trip_n(trip_n),
        .hot_alert_n_i(ha_i), .power_cut(cut));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rw(input logic w, input logic [15:0] a, input logic [63:0] d,
                      input logic [64:0] e);
        @(posedge clk);
        req <= '{1'b1, w, a, d};
        exq.push_back(e);
        @(posedge clk);
        req.valid <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [63:0] d);
        rw(1'b1, a, d, 65'h0);
    endtask

    task automatic rd(input logic [15:0] a, input logic [63:0] e);
        rw(1'b0, a, 64'h0, {1'b1, e});
    endtask

    task automatic feed(input logic [15:0] a, input logic [15:0] b,
                        input logic [1:0] o = 2'b00);
        @(posedge clk);
        smp <= '{1'b1, a, b, o[0], o[1]};
        @(posedge clk);
        smp.valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic cnt(input logic [63:0] e);
        n = 0;
        repeat (2) @(posedge clk);
        repeat (9) begin
            @(posedge clk);
            n += int'(clk_en);
        end
        chk(64'(n), e);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    function automatic logic [15:0] cel(input logic [15:0] k);
        return 16'((32'(k) * 32'h2DB) >> 14) - 16'h0111;
    endfunction

    function automatic logic [15:0] grp(input logic [7:0] th, input logic en,
                                        input logic [1:0] s, input logic [2:0] dv);
        return {1'b0, dv, s, 1'b0, en, th};
    endfunction

    // Read answers are matched against the oldest note
    always @(posedge clk) begin
        if (rsp.ack === 1'b1) begin
            if (exq.size() == 0) begin
                chk(64'h1, 64'h0);
            end else begin
                if (exq[0][64]) begin
                    chk(rsp.rdata, exq[0][63:0]);
                end
                void'(exq.pop_front());
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(32'hFF03FD7D));
        ka = 16'h14B4 + 16'($urandom % 2000);
        kb = ka + 16'h0258;
        ca = cel(ka);
        cb = cel(kb);
        t = cb[7:0] - 8'h01;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFS_PIN, 64'h1);
        rd(OFS_STATUS, 64'h0);
        rd(16'h0010, 64'h0);
        chk({ha_oe, trip_n, clk_en}, 3'b011);
        done("reset");
        wr(OFS_HOT, '1);
        rd(OFS_HOT, IRQ_CTRL_MASK);
        wr(OFS_COLD, '1);
        rd(OFS_COLD, IRQ_CTRL_MASK);
        wr(OFS_THROTTLE, '1);
        rd(OFS_THROTTLE, THROTTLE_MASK);
        wr(OFS_PIN, '1);
        rd(OFS_PIN, PIN_MASK);
        wr(OFS_UNIT_CFG + 16'h0010, 64'h74);
        rd(OFS_UNIT_CFG + 16'h0010, 64'h74);
        chk(64'(ucfg[23:12]), 64'h74);
        wr(OFS_COLD, 64'h0);
        wr(OFS_THROTTLE, 64'h0);
        done("registers");
        feed(ka, kb, 2'b11);
        rd(OFS_SAMPLE, {kb, ka, 6'h0, 2'b11, 24'h0});
        rd(OFS_UNIT_DATA + 16'h0010, {34'h0, kb[13:0], 16'h00F8});
        wr(OFS_CELSIUS, '1);
        rd(OFS_CELSIUS, {32'h0, cb, ca});
        done("readout");
        wr(OFS_HOT, {16'h0, grp(cb[7:0], 1'b1, 2'h1, 3'h0), 16'h0, grp(8'h80, 1'b0, 2'h0, 3'h0)});
        feed(ka, kb);
        rd(OFS_STATUS, 64'h0);
        wr(OFS_HOT, {16'h0, grp(t, 1'b1, 2'h1, 3'h0), 16'h0, grp(8'h80, 1'b0, 2'h0, 3'h0)});
        feed(ka, kb);
        rd(OFS_STATUS, 64'h1);
        feed(ka, ka);
        rd(OFS_STATUS, 64'h1);
        wr(OFS_STATUS, 64'h0);
        rd(OFS_STATUS, 64'h0);
        wr(OFS_COLD, {grp(ca[7:0] + 8'h01, 1'b1, 2'h0, 3'h0), 48'h0});
        feed(ka, ka);
        chk(64'(irq), 64'h2);
        wr(OFS_COLD, 64'h0);
        wr(OFS_STATUS, 64'h5A);
        rd(OFS_STATUS, 64'h0);
        done("interrupts");
        wr(OFS_THR_UPPER, {48'h0, {8{t[7]}}, {8{t[7]}}});
        wr(OFS_THROTTLE, {32'h0, grp(t, 1'b1, 2'h1, 3'h5), grp(t, 1'b1, 2'h1, 3'h3)});
        feed(ka, kb);
        chk({act, div}, 4'hB);
        cnt(64'h3);
        mode <= 1'b1;
        cnt(64'h9);
        mode <= 1'b0;
        wr(OFS_THROTTLE, {32'h0, grp(t, 1'b1, 2'h1, 3'h5), grp(t, 1'b0, 2'h1, 3'h3)});
        feed(ka, kb);
        chk({act, div}, 4'hD);
        wr(OFS_THR_UPPER, {48'h0, 8'h01, {8{t[7]}}});
        feed(ka, kb);
        chk({act, div}, 4'h0);
        wr(OFS_THROTTLE, 64'h0);
        done("throttle");
        wr(OFS_PIN, 64'h0002_0020);
        feed(ka, kb);
        chk({ha_oe, ha_o, trip_n, cut}, 4'b1001);
        wr(OFS_PIN, 64'h0001_0010);
        feed(ka, kb);
        chk({ha_oe, ha_o, trip_n}, 3'b111);
        wr(OFS_PIN, 64'h0601);
        @(posedge clk);
        pull <= 1'b1;
        repeat (4) @(posedge clk);
        chk({ha_oe, act, div}, 5'h0E);
        pull <= 1'b0;
        repeat (4) @(posedge clk);
        chk({act, div}, 4'h0);
        done("pins");
        n = 0;
        while (exq.size() > 0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk(64'(exq.size()), 64'h0);
        end_of_test();
    end
endmodule // tmc_thermal_ctrl_test
